// ===== pkg/qdc_pkg.sv
// Package for the quad DAC channel control block.
// Assumes a single 100 MHz core clock domain; pins are synchronised in the top.
package qdc_pkg;
  localparam int CLK_PERIOD_PS = 10000;
  localparam int PD_EXIT_NS_X10 = 45;
  localparam int PD_EXIT_CYCLES = (PD_EXIT_NS_X10 * 100 * 1000 + CLK_PERIOD_PS - 1)
                                  / CLK_PERIOD_PS;
  localparam logic [1:0] POR_LAST = 2'h2;
  localparam logic [1:0] POR_DONE = 2'h3;
  localparam int NCH = 4;
  localparam int DW = 16;
  localparam int FRAME_BITS = 24;
  localparam logic [4:0] ADDR_HI = 5'h03;
  localparam logic [3:0] CMD_NOP = 4'h0;
  localparam logic [3:0] CMD_WR_IN = 4'h1;
  localparam logic [3:0] CMD_UPD = 4'h2;
  localparam logic [3:0] CMD_WR_UPD = 4'h3;
  localparam logic [3:0] CMD_PWR = 4'h4;
  localparam logic [3:0] CMD_MASK = 4'h5;
  localparam logic [3:0] CMD_SWRST = 4'h6;
  localparam logic [3:0] CMD_REF = 4'h7;
  localparam logic [DW-1:0] ZERO_CODE = 16'h0000;
  localparam logic [DW-1:0] MID_CODE = 16'h8000;
  localparam logic [1:0] PD_NORMAL = 2'h0;
  typedef enum logic [1:0] {QDC_TERM_DRIVE, QDC_TERM_1K, QDC_TERM_100K, QDC_TERM_OPEN}
    qdc_term_t;
  typedef struct packed {
    logic [3:0] cmd;
    logic [3:0] sel;
    logic [DW-1:0] data;
  } qdc_frame_t;
endpackage : qdc_pkg

// ===== hw/qdc_fifo.sv
// Small valid/ready FIFO holding decoded command frames.
// Same clock as its producer and consumer.
`timescale 1ns/1ps
module qdc_fifo #(
  parameter int W = 24,
  parameter int D = 8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0] wp;
  logic [AW:0] rp;
  logic full;
  logic empty;
  assign empty = (wp == rp);
  assign full = (wp[AW-1:0] == rp[AW-1:0]) && (wp[AW] != rp[AW]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rp[AW-1:0]];
  always_ff @(posedge clk) begin
    if (ce && in_valid && !full) begin
      mem[wp[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp <= '0;
      rp <= '0;
    end else if (ce) begin
      if (in_valid && !full) begin
        wp <= wp + 1'b1;
      end
      if (out_ready && !empty) begin
        rp <= rp + 1'b1;
      end
    end
  end
endmodule : qdc_fifo

// ===== hw/qdc_top.sv
// Quad DAC control: two-wire slave, command decode, double-buffered codes.
// Bus pins, strobe and hardware reset pin are asynchronous and synchronised here.
`timescale 1ns/1ps
// Functional notes
// - Repeated start with read address is acknowledged, then data is driven.
// - First two read bytes are selected input register, high byte first.
// - Further byte pairs come from following channels until NACK and stop.
// - After the last channel, readback wraps to the first channel.
// - Command 0100 sets power-down from low eight data bits, two per channel.
// - Code 00 is normal operation; other codes are power-down modes.
// - Power-down output ties to 1k, 100k to ground, or floats.
// - Power-down keeps DAC codes and still accepts DAC updates.
// - Leaving power-down waits 4.5 us before the output is valid.
// - Input and DAC register per channel; writes may select any channels.
// - Strobe low during command 0001 updates input and DAC on 24th bit.
// - Strobe high: DAC updates on a later falling strobe edge.
// - Command 0101 loads four mask bits from DB3..DB0, ignoring channel bits.
// - Mask resets to zero; a set bit ignores the strobe for that channel.
// - Strobe tied low makes the mask irrelevant.
// - Hardware reset clears codes to zero or midscale per level select.
// - While hardware reset is low, no output updates are accepted; bus writes are queued here and applied once it rises.
// - Command 0110 returns DAC to its power-on code.
// - Strobe activity is ignored during power-on reset.
// - Power-up code is zero scale when select low, midscale when high.
// - Reference on after power-up; command 0111 DB0 set turns it off.
// - Frame is 24 bits: command, channel select, data word.
// - Command 0010 copies selected input registers into DAC registers.
// - Command 0011 writes selected DAC registers directly, ignoring the strobe.
// - Bus address is 00011 followed by two strap pins.
module qdc_top
  import qdc_pkg::*;
#(
  parameter int FIFO_DEPTH = 8,
  parameter int PD_EXIT = PD_EXIT_CYCLES
) (
  // Clock, reset, enable
  input  wire logic              I_CORE_CLK,
  input  wire logic              I_SYS_RST,
  input  wire logic              I_CE,
  // Two-wire bus
  input  wire logic              I_SCL,
  input  wire logic              I_SDA,
  output logic                   O_SDA,
  output logic                   O_SDA_OE_N,
  // Device pins
  input  wire logic [1:0]        I_ADDR_STRAP,
  input  wire logic              I_LOAD_STROBE_N,
  input  wire logic              I_HW_RESET_N,
  input  wire logic              I_RESET_LEVEL_SELECT,
  // Channel state
  output logic [NCH*DW-1:0]      O_CHANNEL_OUTPUT,
  output logic [NCH*2-1:0]       O_TERMINATION,
  output logic [NCH-1:0]         O_CHANNEL_VALID,
  output logic                   O_REF_ON
);
  // Two-flop synchronisers for every bus and device pin
  logic [6:0] s1;
  logic [6:0] s2;
  logic [6:0] s3;
  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      s1 <= 7'h7F;
      s2 <= 7'h7F;
      s3 <= 7'h7F;
    end else if (I_CE) begin
      s1 <= {I_ADDR_STRAP, I_RESET_LEVEL_SELECT, I_HW_RESET_N, I_LOAD_STROBE_N, I_SDA,
             I_SCL};
      s2 <= s1;
      s3 <= s2;
    end
  end
  logic scl;
  logic sda;
  logic scl_q;
  logic sda_q;
  logic ld_n;
  logic ld_n_q;
  logic hw_rst_n;
  logic lvl_sel;
  logic [1:0] strap;
  assign scl = s2[0];
  assign sda = s2[1];
  assign ld_n = s2[2];
  assign hw_rst_n = s2[3];
  assign lvl_sel = s2[4];
  assign strap = s2[6:5];
  assign scl_q = s3[0];
  assign sda_q = s3[1];
  assign ld_n_q = s3[2];
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  assign scl_rise = scl && !scl_q;
  assign scl_fall = !scl && scl_q;
  assign start_c = scl && scl_q && sda_q && !sda;
  assign stop_c = scl && scl_q && !sda_q && sda;
  logic ld_fall;
  assign ld_fall = ld_n_q && !ld_n;

  // Power-on window: strobe ignored for a few cycles after reset release
  logic [1:0] por_cnt;
  logic por_busy;
  assign por_busy = (por_cnt != POR_DONE);
  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      por_cnt <= 2'h0;
    end else if (I_CE && por_busy) begin
      por_cnt <= por_cnt + 2'h1;
    end
  end

  // Bus slave state
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACK_A, ST_WDATA, ST_ACK_W, ST_RDATA,
                            ST_ACK_R} qdc_state_t;
  qdc_state_t st;
  logic [3:0] bitn;
  logic [7:0] sh;
  logic [1:0] wbytes;
  logic [15:0] frame_hi;
  logic rd_mode;
  logic [1:0] rd_ptr;
  logic rd_lo;
  logic sda_drv;
  logic match;
  logic [DW-1:0] in_reg [NCH];
  logic fifo_valid;
  logic fifo_ready;
  qdc_frame_t fifo_in;
  qdc_frame_t fifo_out;
  logic push;
  logic pop;

  assign match = (sh[7:1] == {ADDR_HI, strap});

  function automatic logic [7:0] rd_byte(input logic [DW-1:0] v, input logic lo);
    rd_byte = lo ? v[7:0] : v[15:8];
  endfunction : rd_byte

  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      st <= ST_IDLE;
      bitn <= 4'h0;
      sh <= 8'h00;
      wbytes <= 2'h0;
      frame_hi <= 16'h0000;
      rd_mode <= 1'b0;
      rd_ptr <= 2'h0;
      rd_lo <= 1'b0;
      sda_drv <= 1'b0;
      push <= 1'b0;
      fifo_in <= '0;
    end else if (I_CE) begin
      push <= 1'b0;
      if (start_c) begin
        st <= ST_ADDR;
        bitn <= 4'h0;
        sda_drv <= 1'b0;
      end else if (stop_c) begin
        st <= ST_IDLE;
        sda_drv <= 1'b0;
      end else begin
        case (st)
          ST_ADDR: begin
            if (scl_rise) begin
              sh <= {sh[6:0], sda};
              bitn <= bitn + 4'h1;
            end
            if (scl_fall && bitn == 4'h8) begin
              if (match) begin
                st <= ST_ACK_A;
                sda_drv <= 1'b1;
                rd_mode <= sh[0];
                wbytes <= 2'h0;
              end else begin
                st <= ST_IDLE;
              end
            end
          end
          ST_ACK_A: begin
            if (scl_fall) begin
              bitn <= 4'h0;
              if (rd_mode) begin
                st <= ST_RDATA;
                rd_lo <= 1'b0;
                sh <= rd_byte(in_reg[rd_ptr], 1'b0);
                sda_drv <= !in_reg[rd_ptr][15];
              end else begin
                st <= ST_WDATA;
                sda_drv <= 1'b0;
              end
            end
          end
          ST_WDATA: begin
            if (scl_rise) begin
              sh <= {sh[6:0], sda};
              bitn <= bitn + 4'h1;
            end
            if (scl_fall && bitn == 4'h8) begin
              st <= ST_ACK_W;
              // Third byte is refused when the queue is full; that frame is lost
              sda_drv <= fifo_ready || wbytes != 2'h2;
              if (wbytes == 2'h0) begin
                frame_hi[15:8] <= sh;
                // Lowest set select bit picks the first channel read back
                rd_ptr <= sh[0] ? 2'h0 : sh[1] ? 2'h1 :
                          sh[2] ? 2'h2 : sh[3] ? 2'h3 : 2'h0;
              end else if (wbytes == 2'h1) begin
                frame_hi[7:0] <= sh;
              end else begin
                fifo_in <= {frame_hi, sh};
                push <= 1'b1;
              end
              wbytes <= (wbytes == 2'h2) ? 2'h0 : wbytes + 2'h1;
            end
          end
          ST_ACK_W: begin
            if (scl_fall) begin
              st <= ST_WDATA;
              bitn <= 4'h0;
              sda_drv <= 1'b0;
            end
          end
          ST_RDATA: begin
            if (scl_fall) begin
              bitn <= bitn + 4'h1;
              if (bitn == 4'h7) begin
                st <= ST_ACK_R;
                sda_drv <= 1'b0;
              end else begin
                sh <= {sh[6:0], 1'b1};
                sda_drv <= !sh[6];
              end
            end
          end
          ST_ACK_R: begin
            if (scl_rise && sda) begin
              st <= ST_IDLE;
            end else if (scl_fall) begin
              st <= ST_RDATA;
              bitn <= 4'h0;
              if (rd_lo) begin
                rd_ptr <= rd_ptr + 2'h1;
                sh <= rd_byte(in_reg[rd_ptr + 2'h1], 1'b0);
                sda_drv <= !in_reg[rd_ptr + 2'h1][15];
              end else begin
                sh <= rd_byte(in_reg[rd_ptr], 1'b1);
                sda_drv <= !in_reg[rd_ptr][7];
              end
              rd_lo <= !rd_lo;
            end
          end
          default: begin
            st <= ST_IDLE;
          end
        endcase
      end
    end
  end
  assign O_SDA = 1'b0;
  assign O_SDA_OE_N = !sda_drv;

  // Queued frames wait out hardware and power-on reset and run once both lift; system reset empties the queue
  assign pop = hw_rst_n && !por_busy;

  qdc_fifo #(
    .W(FRAME_BITS),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .clk       (I_CORE_CLK),
    .rst       (I_SYS_RST),
    .ce        (I_CE),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   (fifo_in),
    .out_valid (fifo_valid),
    .out_ready (pop),
    .out_data  (fifo_out)
  );

  // Command execution and channel registers
  logic [DW-1:0] dac_reg [NCH];
  logic [7:0] power_down_select;
  logic [3:0] load_strobe_mask;
  logic reference_setup;
  logic [DW-1:0] rst_code;
  logic exec;
  assign rst_code = lvl_sel ? MID_CODE : ZERO_CODE;
  assign exec = fifo_valid && pop;

  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      power_down_select <= 8'h00;
      load_strobe_mask <= 4'h0;
      reference_setup <= 1'b0;
      for (int c = 0; c < NCH; c++) begin
        in_reg[c] <= ZERO_CODE;
        dac_reg[c] <= ZERO_CODE;
      end
    end else if (I_CE) begin
      if (por_busy || !hw_rst_n || (exec && fifo_out.cmd == CMD_SWRST)) begin
        // Level pin is trusted only once synchronised, so no midscale blip
        if (!por_busy || por_cnt == POR_LAST) begin
          for (int c = 0; c < NCH; c++) begin
            in_reg[c] <= rst_code;
            dac_reg[c] <= rst_code;
          end
        end
      end else begin
        if (exec) begin
          case (fifo_out.cmd)
            CMD_PWR: power_down_select <= fifo_out.data[7:0];
            CMD_MASK: load_strobe_mask <= fifo_out.data[3:0];
            CMD_REF: reference_setup <= fifo_out.data[0];
            default: ;
          endcase
        end
        for (int c = 0; c < NCH; c++) begin
          if (exec && fifo_out.sel[c]) begin
            if (fifo_out.cmd == CMD_WR_IN || fifo_out.cmd == CMD_WR_UPD) begin
              in_reg[c] <= fifo_out.data;
            end
            if (fifo_out.cmd == CMD_WR_IN && !ld_n) begin
              dac_reg[c] <= fifo_out.data;
            end else if (fifo_out.cmd == CMD_WR_UPD) begin
              dac_reg[c] <= fifo_out.data;
            end else if (fifo_out.cmd == CMD_UPD) begin
              dac_reg[c] <= in_reg[c];
            end
          end else if (ld_fall && !load_strobe_mask[c]) begin
            dac_reg[c] <= in_reg[c];
          end
        end
      end
    end
  end

  // Power-down termination table and exit timer
  function automatic qdc_term_t term_map(input logic [1:0] code);
    case (code)
      2'h1: term_map = QDC_TERM_1K;
      2'h2: term_map = QDC_TERM_100K;
      2'h3: term_map = QDC_TERM_OPEN;
      default: term_map = QDC_TERM_DRIVE;
    endcase
  endfunction : term_map

  logic [15:0] exit_cnt [NCH];
  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_TERMINATION <= '0;
      O_CHANNEL_VALID <= '0;
      O_REF_ON <= 1'b1;
      O_CHANNEL_OUTPUT <= '0;
      for (int c = 0; c < NCH; c++) begin
        exit_cnt[c] <= 16'h0000;
      end
    end else if (I_CE) begin
      O_REF_ON <= !reference_setup;
      for (int c = 0; c < NCH; c++) begin
        O_CHANNEL_OUTPUT[c*DW +: DW] <= dac_reg[c];
        O_TERMINATION[c*2 +: 2] <= term_map(power_down_select[c*2 +: 2]);
        if (power_down_select[c*2 +: 2] != PD_NORMAL) begin
          exit_cnt[c] <= 16'h0000;
          O_CHANNEL_VALID[c] <= 1'b0;
        end else if (exit_cnt[c] < 16'(PD_EXIT)) begin
          exit_cnt[c] <= exit_cnt[c] + 16'h0001;
          O_CHANNEL_VALID[c] <= 1'b0;
        end else begin
          O_CHANNEL_VALID[c] <= 1'b1;
        end
      end
    end
  end
endmodule : qdc_top

// ===== dv/qdc_chk.sv
// Assertion checker for the quad DAC control top, bound to qdc_top.
// Sees the top ports only; assumes the clock enable is held high.
`timescale 1ns/1ps
module qdc_chk
  import qdc_pkg::*;
#(
  parameter int PD_EXIT = PD_EXIT_CYCLES
) (
  // Clock and reset
  input  wire logic              I_CORE_CLK,
  input  wire logic              I_SYS_RST,
  // Pins
  input  wire logic              I_SCL,
  input  wire logic              O_SDA_OE_N,
  input  wire logic              I_HW_RESET_N,
  input  wire logic              I_RESET_LEVEL_SELECT,
  // Channel state
  input  wire logic [NCH*DW-1:0] O_CHANNEL_OUTPUT,
  input  wire logic [NCH*2-1:0]  O_TERMINATION,
  input  wire logic [NCH-1:0]    O_CHANNEL_VALID,
  input  wire logic              O_REF_ON
);
  logic [DW-1:0] rcode;
  int            since;

  assign rcode = I_RESET_LEVEL_SELECT ? MID_CODE : ZERO_CODE;

  // Cycles since channel 3 left power-down; saturates so reset looks long ago
  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST)
      since <= 1000;
    else if (O_TERMINATION[7:6] != PD_NORMAL)
      since <= 0;
    else if (since < 1000)
      since <= since + 1;
  end

  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_SYS_RST);

  AST_POR_CODE: assert property ($fell(I_SYS_RST) |-> ##6 O_CHANNEL_OUTPUT == {NCH{rcode}})
    else $error("power-up code wrong");
  AST_POR_REF: assert property ($fell(I_SYS_RST) |-> O_REF_ON)
    else $error("reference off after reset");
  AST_HWRST_CODE: assert property (!I_HW_RESET_N [*5] |-> O_CHANNEL_OUTPUT == {NCH{rcode}})
    else $error("hardware reset code wrong");
  AST_HWRST_FREEZE: assert property (!I_HW_RESET_N [*4] |=> $stable(O_TERMINATION) && $stable(O_REF_ON))
    else $error("state changed under hardware reset");
  AST_ACK_IN_LOW: assert property ($fell(O_SDA_OE_N) |-> !I_SCL)
    else $error("data driven while bus clock high");
  AST_SDA_HOLD: assert property (I_SCL [*3] |-> $stable(O_SDA_OE_N))
    else $error("data changed while bus clock high");
  AST_PD_KEEPS: assert property ($changed(O_TERMINATION) |-> $stable(O_CHANNEL_OUTPUT))
    else $error("power-down altered codes");
  AST_REF_KEEPS: assert property ($changed(O_REF_ON) |-> $stable(O_CHANNEL_OUTPUT) && $stable(O_TERMINATION))
    else $error("reference change altered channels");
  AST_PD_INVALID: assert property (O_TERMINATION[7:6] != PD_NORMAL |-> ##1 !O_CHANNEL_VALID[3])
    else $error("powered-down channel marked valid");
  AST_EXIT_MIN: assert property ($rose(O_CHANNEL_VALID[3]) |-> since >= PD_EXIT - 1)
    else $error("valid before exit delay");
  AST_EXIT_MAX: assert property (since == PD_EXIT + 6 |-> O_CHANNEL_VALID[3])
    else $error("valid late after exit delay");
endmodule : qdc_chk

bind qdc_top qdc_chk #(.PD_EXIT(PD_EXIT)) u_chk (.*);

// ===== dv/qdc_master.sv
// Two-wire bus master model for the DAC control block.
// Assumes a pull-up on the data wire; the clock stands still between frames.
`timescale 1ns/1ps
module qdc_master (
  // Bus pins
  output logic      o_scl,
  output logic      o_sda,
  input  wire logic i_sda
);
  localparam realtime Q = 31.25;

  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  // Data moves only while the clock is low
  task automatic xbit(input logic b, output logic r);
    o_sda = b;
    #Q o_scl = 1'b1;
    #Q r = i_sda;
    #Q o_scl = 1'b0;
    #Q;
  endtask : xbit

  task automatic start();
    o_sda = 1'b1;
    #Q o_scl = 1'b1;
    #Q o_sda = 1'b0;
    #Q o_scl = 1'b0;
    #Q;
  endtask : start

  task automatic stop();
    o_sda = 1'b0;
    #Q o_scl = 1'b1;
    #Q o_sda = 1'b1;
    #(2 * Q);
  endtask : stop

  task automatic wbyte(input logic [7:0] d, output logic nak);
    logic r;
    for (int i = 7; i >= 0; i--) xbit(d[i], r);
    xbit(1'b1, nak);
  endtask : wbyte

  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) xbit(1'b1, d[i]);
    xbit(last, r);
  endtask : rbyte
endmodule : qdc_master

// ===== dv/tb_top.sv
// Self-checking bench for the quad DAC control block.
// Bus traffic comes from the master model; pins change 1 ns after a core edge.
`timescale 1ns/1ps
module tb_top;
  import qdc_pkg::*;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              strb_n = 1'b1;
  logic              hw_n = 1'b1;
  logic              lvl = 1'b0;
  logic [1:0]        strap = 2'h2;
  logic              scl, msda, oe_n, sda_o, ref_on;
  logic [NCH*DW-1:0] outs;
  logic [NCH*2-1:0]  term;
  logic [NCH-1:0]    vld;
  logic [DW-1:0]     inr [NCH] = '{default: 16'h0000};
  logic [DW-1:0]     dac [NCH] = '{default: 16'h0000};
  int                bad_count, checks, cyc;
  wire               sda = msda & (oe_n | sda_o);

  always #5 clk = ~clk;

  qdc_master m (.o_scl(scl), .o_sda(msda), .i_sda(sda));
  qdc_top #(.FIFO_DEPTH(8), .PD_EXIT(5)) dut (
    .I_CORE_CLK(clk), .I_SYS_RST(rst), .I_CE(1'b1), .I_SCL(scl), .I_SDA(sda),
    .O_SDA(sda_o), .O_SDA_OE_N(oe_n), .I_ADDR_STRAP(strap), .I_LOAD_STROBE_N(strb_n),
    .I_HW_RESET_N(hw_n), .I_RESET_LEVEL_SELECT(lvl), .O_CHANNEL_OUTPUT(outs),
    .O_TERMINATION(term), .O_CHANNEL_VALID(vld), .O_REF_ON(ref_on));

  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic give_verdict();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict

  function automatic logic [63:0] expo();
    return {dac[3], dac[2], dac[1], dac[0]};
  endfunction : expo

  task automatic put(input logic [3:0] s, input logic [15:0] d, input logic i, input logic o);
    for (int k = 0; k < NCH; k++) begin
      if (s[k] && i) inr[k] = d;
      if (s[k] && o) dac[k] = d;
    end
  endtask : put

  task automatic send(input logic [3:0] c, input logic [3:0] s, input logic [15:0] d);
    logic [3:0] n;
    m.start();
    m.wbyte({ADDR_HI, strap, 1'b0}, n[3]);
    m.wbyte({c, s}, n[2]);
    m.wbyte(d[15:8], n[1]);
    m.wbyte(d[7:0], n[0]);
    m.stop();
    repeat (6) @(posedge clk);
    cmp(n, 0);
  endtask : send

  task automatic pulse();
    @(posedge clk) #1 strb_n = 1'b0;
    repeat (8) @(posedge clk);
    #1 strb_n = 1'b1;
    repeat (8) @(posedge clk);
  endtask : pulse

  task automatic t_power_up();
    cmp(outs, expo());
    cmp(ref_on, 1'b1);
    cmp(term, 0);
    cmp({sda_o, oe_n}, 2'b01);
  endtask : t_power_up

  task automatic t_bad_address();
    logic n;
    m.start();
    m.wbyte({ADDR_HI, ~strap, 1'b0}, n);
    m.stop();
    cmp(n, 1'b1);
  endtask : t_bad_address

  task automatic t_write_paths();
    send(CMD_WR_UPD, 4'h1, 16'h1234);
    put(4'h1, 16'h1234, 1'b1, 1'b1);
    cmp(outs, expo());
    send(CMD_WR_IN, 4'h6, 16'hABCD);
    put(4'h6, 16'hABCD, 1'b1, 1'b0);
    cmp(outs, expo());
    pulse();
    put(4'h6, 16'hABCD, 1'b0, 1'b1);
    cmp(outs, expo());
  endtask : t_write_paths

  task automatic t_mask();
    send(CMD_MASK, 4'h9, 16'h0002);
    send(CMD_WR_IN, 4'h3, 16'h5555);
    put(4'h3, 16'h5555, 1'b1, 1'b0);
    pulse();
    put(4'h1, 16'h5555, 1'b0, 1'b1);
    cmp(outs, expo());
    send(CMD_UPD, 4'h2, 16'h0000);
    put(4'h2, 16'h5555, 1'b0, 1'b1);
    cmp(outs, expo());
    #1 strb_n = 1'b0;
    send(CMD_WR_IN, 4'h2, 16'h8888);
    put(4'h2, 16'h8888, 1'b1, 1'b1);
    cmp(outs, expo());
    #1 strb_n = 1'b1;
  endtask : t_mask

  task automatic t_readback();
    logic        n0, n1, n2;
    logic [15:0] b;
    m.start();
    m.wbyte({ADDR_HI, strap, 1'b0}, n0);
    m.wbyte({CMD_NOP, 4'h5}, n1);
    m.start();
    m.wbyte({ADDR_HI, strap, 1'b1}, n2);
    cmp({n0, n1, n2}, 0);
    for (int k = 0; k < 5; k++) begin
      m.rbyte(1'b0, b[15:8]);
      m.rbyte(k == 4, b[7:0]);
      cmp(b, inr[k % NCH]);
    end
    m.stop();
  endtask : t_readback

  task automatic t_power_down();
    send(CMD_PWR, 4'h0, 16'h00E4);
    cmp(term, 8'hE4);
    cmp(vld, 4'h1);
    cmp(outs, expo());
    send(CMD_WR_UPD, 4'h8, 16'h4321);
    put(4'h8, 16'h4321, 1'b1, 1'b1);
    cmp(outs, expo());
    send(CMD_PWR, 4'h0, 16'h0000);
    cmp(term, 8'h00);
    cmp(vld, 4'hF);
  endtask : t_power_down

  task automatic t_reference();
    for (int v = 1; v >= 0; v--) begin
      send(CMD_REF, 4'h0, 16'(v));
      cmp(ref_on, !v[0]);
    end
  endtask : t_reference

  task automatic t_resets();
    send(CMD_SWRST, 4'h0, 16'h0000);
    put(4'hF, ZERO_CODE, 1'b1, 1'b1);
    cmp(outs, expo());
    @(posedge clk) #1 lvl = 1'b1;
    hw_n = 1'b0;
    repeat (8) @(posedge clk);
    put(4'hF, MID_CODE, 1'b1, 1'b1);
    cmp(outs, expo());
    send(CMD_WR_UPD, 4'h1, 16'h2222);
    pulse();
    cmp(outs, expo());
    #1 hw_n = 1'b1;
    repeat (12) @(posedge clk);
    put(4'h1, 16'h2222, 1'b1, 1'b1);
    cmp(outs, expo());
  endtask : t_resets

  initial begin
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    repeat (12) @(posedge clk);
    t_power_up();
    t_bad_address();
    t_write_paths();
    t_mask();
    t_readback();
    t_power_down();
    t_reference();
    t_resets();
    give_verdict();
  end

  // Hang guard: the full run needs well under a third of this
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      $display("mismatch at %0t: run did not finish", $time);
      give_verdict();
    end
  end
endmodule : tb_top
